// file: src/fis_core.sv
// fault_interrupt_status core: current-limit code, fault status, fault mask and interrupt
// assumes serial decode upstream in clk_sys domain; analog conditions arrive from pins
`timescale 1ns/1ps

module fis_core (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire fis_pkg::fis_req_s req,
  output logic [7:0] rdata,
  input wire fis_pkg::fis_cond_s cond_pin,
  input wire logic power_bad_latch_enable,
  output logic [2:0] avg_current_limit_code,
  output logic irq_n
);
  import fis_pkg::*;

  // three-stage sync per condition; change accepted when stages 2 and 3 agree
  localparam int NC = $bits(fis_cond_s);
  logic [NC-1:0] s1_q, s2_q, s3_q, flt_q;
  logic [NC-1:0] s1_d, s2_d, s3_d, flt_d;
  fis_cond_s cond;

  always_comb
  begin
    s1_d = cond_pin;
    s2_d = s1_q;
    s3_d = s2_q;
    flt_d = flt_q;
    for (int i = 0; i < NC; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        flt_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      flt_q <= '0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      flt_q <= flt_d;
    end
  end

  assign cond = flt_q;

  // register state
  logic [2:0] code_q, code_d;
  logic [7:0] status_q, status_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;

  // decoded strobes and per-source views
  logic [7:0] raw;
  logic [7:0] status_view;
  logic [7:0] status_next_view;
  logic clear_all;
  logic code_write;
  logic mask_write;
  logic mapped_read;
  logic overvoltage_flag;
  logic overcurrent_flag;
  logic power_not_good_flag;
  logic overvoltage_alert_mask;
  logic overcurrent_alert_mask;
  logic power_bad_alert_mask;

  // live fault vector in status bit order
  always_comb
  begin
    raw = '0;
    raw[FIS_BIT_TEMP] = cond.over_temp;
    raw[FIS_BIT_VOLT] = cond.over_volt;
    // all three causes at once, a bare trip during soft-start is not a fault
    raw[FIS_BIT_CURR] = cond.cycle_limit & cond.fb_below_60pct & cond.soft_start_done;
    raw[FIS_BIT_PBAD] = cond.vout_above_upper | cond.vout_below_lower;
  end

  // only the exact all-ones byte clears; any other status write is dropped
  assign clear_all = req.wr && req.addr == FIS_ADDR_STATUS && req.wdata == FIS_CLEAR_ALL;
  assign code_write = req.wr && req.addr == FIS_ADDR_CODE;
  assign mask_write = req.wr && req.addr == FIS_ADDR_MASK;
  assign mapped_read = req.addr == FIS_ADDR_CODE || req.addr == FIS_ADDR_STATUS
    || req.addr == FIS_ADDR_MASK;

  // unlatched power-bad bit replaced by the live condition
  function automatic logic [7:0] pbad_view(input logic [7:0] s, input logic [7:0] r);
    logic [7:0] v;
    v = s;
    if (!power_bad_latch_enable)
    begin
      v[FIS_BIT_PBAD] = r[FIS_BIT_PBAD];
    end
    return v;
  endfunction : pbad_view

  always_comb
  begin
    code_d = code_q;
    mask_d = mask_q;
    status_d = status_q;
    if (code_write)
    begin
      code_d = req.wdata[2:0];
    end
    if (mask_write)
    begin
      // unused mask positions never hold a one
      mask_d = req.wdata & FIS_STATUS_USED;
    end
    if (clear_all)
    begin
      status_d = '0;
    end
    // a condition present in the clearing cycle sets again: set wins
    status_d = status_d | (raw & FIS_LATCHED);
    if (power_bad_latch_enable)
    begin
      status_d[FIS_BIT_PBAD] = status_d[FIS_BIT_PBAD] | raw[FIS_BIT_PBAD];
    end
    else
    begin
      status_d[FIS_BIT_PBAD] = 1'b0;
    end
  end

  always_comb
  begin
    status_view = pbad_view(status_q, raw);
    status_next_view = pbad_view(status_d, raw);
  end

  always_comb
  begin
    rdata_d = rdata_q;
    if (req.rd)
    begin
      unique case (req.addr)
        FIS_ADDR_CODE: rdata_d = {5'h00, code_q};
        FIS_ADDR_STATUS: rdata_d = status_view;
        FIS_ADDR_MASK: rdata_d = mask_q;
        default: rdata_d = 8'h00;
      endcase
    end
    // from next state, so the pin moves on the same edge as a latched status bit, one edge after the live unlatched power-bad bit
    irq_d = |(status_next_view & ~mask_d);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      code_q <= FIS_CODE_RESET;
      status_q <= '0;
      mask_q <= FIS_MASK_RESET;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      code_q <= code_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign rdata = rdata_q;
  assign avg_current_limit_code = code_q;
  // interrupt pin is active low, idle high
  assign irq_n = ~irq_q;

  assign overvoltage_flag = status_q[FIS_BIT_VOLT];
  assign overcurrent_flag = status_q[FIS_BIT_CURR];
  assign power_not_good_flag = status_view[FIS_BIT_PBAD];
  assign overvoltage_alert_mask = mask_q[FIS_BIT_VOLT];
  assign overcurrent_alert_mask = mask_q[FIS_BIT_CURR];
  assign power_bad_alert_mask = mask_q[FIS_BIT_PBAD];

  latched_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !clear_all |=> (($past(status_q) & FIS_LATCHED & ~status_q) == 8'h00))
    else $error("latched flag dropped without clear");
  volt_sticky_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    overvoltage_flag && !clear_all |=> overvoltage_flag)
    else $error("over-voltage flag dropped without clear");
  clear_all_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clear_all && raw == 8'h00 |=> status_q == 8'h00 && irq_n)
    else $error("status not cleared by all-ones write");
  curr_cause_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(overcurrent_flag) |-> $past(cond.cycle_limit && cond.fb_below_60pct
      && cond.soft_start_done))
    else $error("over-current flag set without all three causes");
  temp_report_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cond.over_temp |=> status_q[FIS_BIT_TEMP])
    else $error("over-temperature not reported");
  volt_report_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cond.over_volt |=> overvoltage_flag)
    else $error("over-voltage not reported");
  pbad_live_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !power_bad_latch_enable |-> power_not_good_flag == raw[FIS_BIT_PBAD])
    else $error("unlatched power-bad not live");
  pbad_window_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    power_bad_latch_enable && (cond.vout_above_upper || cond.vout_below_lower)
      |=> status_q[FIS_BIT_PBAD])
    else $error("power-bad not set on window exit");
  mask_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mask_d == FIS_STATUS_USED |=> irq_n)
    else $error("fully masked interrupt asserted");
  masked_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    |(raw & FIS_LATCHED & mask_q) |=> |(status_q & FIS_LATCHED & $past(mask_q)))
    else $error("masked source did not set its status bit");
  irq_rel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> irq_n == !$past(|(status_next_view & ~mask_d)))
    else $error("interrupt does not match status and mask");
  code_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    code_write |=> avg_current_limit_code == $past(req.wdata[2:0]))
    else $error("current-limit code not written");
  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    req.rd && !mapped_read |=> rdata == 8'h00)
    else $error("unmapped offset read not zero");
  mask_unused_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mask_q & ~FIS_STATUS_USED) == 8'h00)
    else $error("unused mask bit set");
  reset_val_a: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> mask_q == FIS_MASK_RESET && code_q == FIS_CODE_RESET)
    else $error("wrong reset value for mask or code");
  reset_irq_a: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> irq_n && status_q == 8'h00 && power_bad_alert_mask)
    else $error("interrupt or status not idle after reset");

  // limitation: the code only selects a threshold; the analog limit lives elsewhere
  // trade-off: one extra filter stage of latency buys immunity to single-cycle glitches
  // note: status bit 3 is unused and always reads zero
  // note: the latch setting is taken as a same-domain level, no synchroniser
endmodule : fis_core

// file: src/fis_pkg.sv
// fault_interrupt_status package: register offsets, field positions, reset values, carriers
// assumes an upstream two-wire serial decoder that presents byte-wide register accesses
package fis_pkg;
  localparam logic [7:0] FIS_ADDR_CODE = 8'h04;
  localparam logic [7:0] FIS_ADDR_STATUS = 8'h05;
  localparam logic [7:0] FIS_ADDR_MASK = 8'h06;
  localparam logic [7:0] FIS_CLEAR_ALL = 8'hFF;
  localparam logic [2:0] FIS_CODE_RESET = 3'h1;
  localparam int FIS_BIT_TEMP = 4;
  localparam int FIS_BIT_VOLT = 2;
  localparam int FIS_BIT_CURR = 1;
  localparam int FIS_BIT_PBAD = 0;
  localparam logic [7:0] FIS_STATUS_USED = 8'h17;
  localparam logic [7:0] FIS_MASK_RESET = 8'h01;
  localparam logic [7:0] FIS_LATCHED = 8'h16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fis_req_s;

  typedef struct packed {
    logic over_temp;
    logic over_volt;
    logic cycle_limit;
    logic fb_below_60pct;
    logic soft_start_done;
    logic vout_above_upper;
    logic vout_below_lower;
  } fis_cond_s;
endpackage : fis_pkg

// file: test/fis_host.sv
// fis_host: host model issuing byte register accesses
// assumes clk_sys domain; one-cycle strobes, idle cycle between accesses
`timescale 1ns/1ps
module fis_host (
  input wire logic clk_sys,
  output fis_pkg::fis_req_s req
);
  import fis_pkg::*;
  initial req = '0;
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys);
    #1 req = '0;
  endtask : access
endmodule : fis_host

// file: test/test_fault_interrupt_status.sv
// test_fault_interrupt_status: self-checking bench for fis_core
// assumes fis_host drives registers; fault pins are driven here
`timescale 1ns/1ps
module test_fault_interrupt_status;
  import fis_pkg::*;
  logic clk_sys;
  logic reset_n;
  fis_req_s req;
  fis_cond_s cond_pin;
  logic power_bad_latch_enable;
  logic [7:0] rdata;
  logic [2:0] avg_current_limit_code;
  logic irq_n;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] code_v;
  logic [6:0] cv_t[4] = '{7'h40, 7'h20, 7'h1C, 7'h01};
  logic [7:0] st_t[4] = '{8'h10, 8'h04, 8'h02, 8'h01};
  int n_fail = 0;
  int num_checks = 0;
  integer seed = 32'h9dbb5c2a;
  fis_core dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .req(req), .rdata(rdata),
    .cond_pin(cond_pin), .power_bad_latch_enable(power_bad_latch_enable),
    .avg_current_limit_code(avg_current_limit_code), .irq_n(irq_n));
  fis_host host_u (.clk_sys(clk_sys), .req(req));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic irq(input logic e);
    check("irq_n", {7'h0, irq_n}, {7'h0, e});
  endtask : irq
  // fault pulse, then condition removed so only latched bits remain
  task automatic fault(input logic [6:0] cv, input logic [7:0] st, input logic e);
    cond_pin = cv;
    repeat (8) @(posedge clk_sys);
    #1 cond_pin = '0;
    repeat (8) @(posedge clk_sys);
    #1 rd(FIS_ADDR_STATUS, st);
    irq(e);
  endtask : fault
  always @(posedge clk_sys)
  begin
    rd_q <= req.rd;
    if (rd_q === 1'b1)
      check("rdata", rdata, exp_q.pop_front());
  end
  initial
  begin
    reset_n = 1'b0;
    cond_pin = '0;
    power_bad_latch_enable = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    check("code", {5'h0, avg_current_limit_code}, {5'h0, FIS_CODE_RESET});
    irq(1'b1);
    rd(FIS_ADDR_CODE, 8'h01);
    rd(FIS_ADDR_MASK, FIS_MASK_RESET);
    rd(FIS_ADDR_STATUS, 8'h00);
    code_v = 8'($random(seed));
    wr(FIS_ADDR_CODE, code_v);
    rd(FIS_ADDR_CODE, {5'h0, code_v[2:0]});
    check("code", {5'h0, avg_current_limit_code}, {5'h0, code_v[2:0]});
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    wr(FIS_ADDR_MASK, 8'hFF);
    rd(FIS_ADDR_MASK, FIS_STATUS_USED);
    fault(7'h20, 8'h04, 1'b1);
    wr(FIS_ADDR_STATUS, FIS_CLEAR_ALL);
    fault(7'h18, 8'h00, 1'b1);
    fault(7'h14, 8'h00, 1'b1);
    power_bad_latch_enable = 1'b1;
    wr(FIS_ADDR_MASK, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      fault(cv_t[i], st_t[i], 1'b0);
      wr(FIS_ADDR_MASK, st_t[i]);
      #1 irq(1'b1);
      rd(FIS_ADDR_STATUS, st_t[i]);
      wr(FIS_ADDR_MASK, 8'h00);
      wr(FIS_ADDR_STATUS, 8'h55);
      rd(FIS_ADDR_STATUS, st_t[i]);
      wr(FIS_ADDR_STATUS, FIS_CLEAR_ALL);
      rd(FIS_ADDR_STATUS, 8'h00);
      irq(1'b1);
    end
    power_bad_latch_enable = 1'b0;
    cond_pin = 7'h02;
    repeat (8) @(posedge clk_sys);
    #1 irq(1'b0);
    rd(FIS_ADDR_STATUS, 8'h01);
    cond_pin = '0;
    repeat (8) @(posedge clk_sys);
    #1 rd(FIS_ADDR_STATUS, 8'h00);
    irq(1'b1);
    repeat (3) @(posedge clk_sys);
    check("queue", 8'(exp_q.size()), 8'h00);
    summarize();
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
endmodule : test_fault_interrupt_status
